// ===== fdd_option_pkg.sv
// package for the flexible disk drive option control block
// assumes a single 40 MHz clock and an AHB-Lite master reaching the status registers

package fdd_option_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_HZ = 40_000_000;
  // two index pulses must fall within this window for a disk to count as seated
  localparam int unsigned INDEX_WINDOW_MS = 300;
  localparam int unsigned INDEX_WINDOW_CYCLES = (CLK_HZ / 1000) * INDEX_WINDOW_MS;
  localparam int CNT_W = 24;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses, one word each)
  localparam logic [7:0] OFF_STATE = 8'h00;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h04;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h08;
  localparam logic [1:0] REG_NONE = 2'h0;
  localparam logic [1:0] REG_STATE = 2'h1;
  localparam logic [1:0] REG_IRQ_STATUS = 2'h2;
  localparam logic [1:0] REG_IRQ_MASK = 2'h3;

  // interrupt event bits
  localparam int EV_N = 3;
  localparam int EV_READY = 0;
  localparam int EV_EJECT = 1;
  localparam int EV_LOST = 2;
  localparam logic [EV_N-1:0] IRQ_MASK_RST = 3'h0;

  // jumper encodings
  localparam logic [1:0] HL_SEL_READYOUT = 2'h1;
  localparam logic [1:0] HL_SEL_CURRENT = 2'h2;
  localparam logic [1:0] HL_SEL_HELD = 2'h3;
  localparam logic [1:0] RDY_OUT_CURRENT = 2'h2;
  localparam logic [1:0] RDY_OUT_HELD = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    DISK_EMPTY = 2'h0,
    DISK_SPINUP = 2'h1,
    DISK_READY = 2'h3
  } disk_t;

  // drive interface pins, all active low
  typedef struct packed {
    logic motorOnN;
    logic [3:0] unitSelN;
    logic inUseN;
    logic indexN;
    logic diskInN;
    logic wpSenseN;
  } pins_t;

  // option jumpers and traces, high = fitted (plug in) or cut (trace)
  typedef struct packed {
    logic motorFollowsMotorLine;
    logic motorFollowsSelect;
    logic motorAlwaysWithDisk;
    logic inuseInputCut;
    logic continuousSelect;
    logic headloadOnSelect;
    logic headloadOnMotor;
    logic headloadConstant;
    logic [1:0] hlReadySel;
    logic [1:0] readyOutSel;
    logic wpInvert;
    logic [3:0] unitSelect;
  } opts_t;

  typedef struct packed {
    pins_t pins;
    opts_t opts;
  } sync_t;

  typedef struct packed {
    sync_t s1;
    sync_t s2;
    sync_t s3;
    sync_t f;
    logic prevIndexN;
    logic [CNT_W-1:0] idxCnt;
    logic seenOne;
    logic curReady;
    disk_t disk;
    logic motorRun;
    logic headLoad;
    logic readyOutN;
    logic ledOn;
    logic wpOutN;
    logic [EV_N-1:0] irqStat;
    logic [EV_N-1:0] irqMask;
    logic irq;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdata;
    logic hreadyOut;
    logic hresp;
  } state_t;

  localparam pins_t PINS_IDLE = pins_t'(9'h1FF);
  localparam sync_t SYNC_RST = '{pins: PINS_IDLE, opts: opts_t'(17'h00000)};
  localparam state_t STATE_RST = '{s1: SYNC_RST, s2: SYNC_RST, s3: SYNC_RST, f: SYNC_RST,
                                   prevIndexN: 1'b1, disk: DISK_EMPTY, readyOutN: 1'b1,
                                   wpOutN: 1'b1, irqMask: IRQ_MASK_RST, hreadyOut: 1'b1,
                                   default: '0};

endpackage

// ===== floppy_drive_option_control.sv
// option-selected motor, head-load, ready, indicator and write-protect logic of a disk drive
// assumes drive pins and jumpers arrive asynchronously; AHB-Lite slave for status and interrupts
//
// Register access over AHB-Lite and the address map were chosen for this implementation.

`timescale 1ns/1ps

module floppy_drive_option_control
  import fdd_option_pkg::*;
#(
  parameter logic [CNT_W-1:0] WINDOW_CYCLES = CNT_W'(INDEX_WINDOW_CYCLES)
) (
  input wire logic clk,
  input wire logic rst,
  input wire pins_t pinsIn,
  input wire opts_t optsIn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic motorRun,
  output logic headLoad,
  output logic readyOutN,
  output logic ledOn,
  output logic wpOutN,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // decode

  function automatic logic [1:0] regSel(input logic [7:0] a);
    case (a)
      OFF_STATE: regSel = REG_STATE;
      OFF_IRQ_STATUS: regSel = REG_IRQ_STATUS;
      OFF_IRQ_MASK: regSel = REG_IRQ_MASK;
      default: regSel = REG_NONE;
    endcase
  endfunction

  state_t q;
  state_t n;
  pins_t p;
  opts_t o;
  logic diskIn;
  logic anySel;
  logic selected;
  logic idxFall;
  logic pairOk;
  logic timeout;
  logic heldReady;
  logic readySel;
  logic readyQual;
  logic hlSource;
  logic acc;
  logic [EV_N-1:0] ev;
  logic [EV_N-1:0] clr;

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = q;
    // straps and pins pass three flops; a change counts once the last two agree
    n.s1 = '{pins: pinsIn, opts: optsIn};
    n.s2 = q.s1;
    n.s3 = q.s2;
    if (q.s2 == q.s3) begin
      n.f = q.s3;
    end
    p = q.f.pins;
    o = q.f.opts;
    diskIn = ~p.diskInN;
    anySel = |(~p.unitSelN);
    selected = o.continuousSelect | (|(~p.unitSelN & o.unitSelect));
    heldReady = (q.disk == DISK_READY);

    // index pulse pair detection; a badly seated disk never gives the second edge in time
    idxFall = q.prevIndexN & ~p.indexN;
    n.prevIndexN = p.indexN;
    pairOk = idxFall & q.seenOne & (q.idxCnt < WINDOW_CYCLES);
    timeout = (q.idxCnt == WINDOW_CYCLES);
    if (!diskIn || idxFall) begin
      n.idxCnt = '0;
    end else if (!timeout) begin
      n.idxCnt = CNT_W'(q.idxCnt + 1'b1);
    end
    if (!diskIn) begin
      n.seenOne = 1'b0;
    end else if (idxFall) begin
      n.seenOne = 1'b1;
    end else if (timeout) begin
      n.seenOne = 1'b0;
    end

    // current ready drops as soon as the index stops arriving in time
    if (!diskIn) begin
      n.curReady = 1'b0;
    end else if (pairOk) begin
      n.curReady = 1'b1;
    end else if (timeout) begin
      n.curReady = 1'b0;
    end

    // disk state: insertion spins up, a valid pair seats it, eject empties it
    case (q.disk)
      DISK_EMPTY: begin
        if (diskIn) begin
          n.disk = DISK_SPINUP;
        end
      end
      DISK_SPINUP: begin
        if (!diskIn) begin
          n.disk = DISK_EMPTY;
        end else if (pairOk) begin
          n.disk = DISK_READY;
        end
      end
      DISK_READY: begin
        if (!diskIn) begin
          n.disk = DISK_EMPTY;
        end
      end
      default: begin
        n.disk = DISK_EMPTY;
      end
    endcase

    // spindle sources are or-ed; the insertion spin-up ends once the disk is seated
    n.motorRun = (q.disk == DISK_SPINUP)
               | (o.motorFollowsMotorLine & ~p.motorOnN)
               | (o.motorFollowsSelect & anySel)
               | (o.motorAlwaysWithDisk & diskIn);

    // ready output; option 4 or no jumper leaves the line inactive
    case (o.readyOutSel)
      RDY_OUT_CURRENT: readySel = q.curReady;
      RDY_OUT_HELD: readySel = heldReady;
      default: readySel = 1'b0;
    endcase
    n.readyOutN = ~readySel;

    case (o.hlReadySel)
      HL_SEL_READYOUT: readyQual = readySel;
      HL_SEL_CURRENT: readyQual = q.curReady;
      HL_SEL_HELD: readyQual = heldReady;
      default: readyQual = 1'b0;
    endcase
    hlSource = (o.headloadOnSelect & selected)
             | (o.headloadOnMotor & ~p.motorOnN)
             | o.headloadConstant;
    n.headLoad = hlSource & readyQual;

    // continuous select would keep the lamp lit, so the cut variant masks it entirely
    if (o.inuseInputCut) begin
      n.ledOn = selected & ~o.continuousSelect;
    end else begin
      n.ledOn = selected | ~p.inUseN;
    end

    n.wpOutN = p.wpSenseN ^ o.wpInvert;

    // bus: zero wait states, read data loaded at the address phase edge
    acc = hsel & htrans[1] & hready;
    n.hreadyOut = 1'b1;
    n.hresp = 1'b0;
    n.wrPend = acc & hwrite;
    n.wrAddr = haddr[7:0];
    clr = '0;
    if (acc && !hwrite) begin
      case (regSel(haddr[7:0]))
        REG_STATE: n.rdata = {22'h000000, q.disk, q.wpOutN, q.readyOutN, q.ledOn, q.headLoad,
                              q.motorRun, diskIn, heldReady, q.curReady};
        REG_IRQ_STATUS: begin
          n.rdata = {29'h00000000, q.irqStat};
          clr = '1;
        end
        REG_IRQ_MASK: n.rdata = {29'h00000000, q.irqMask};
        default: n.rdata = 32'h00000000;
      endcase
    end
    if (q.wrPend && regSel(q.wrAddr) == REG_IRQ_MASK) begin
      n.irqMask = hwdata[EV_N-1:0];
    end

    // a new event in the clearing cycle survives the read-clear
    ev = '0;
    ev[EV_READY] = pairOk & (q.disk == DISK_SPINUP);
    ev[EV_EJECT] = ~diskIn & (q.disk != DISK_EMPTY);
    ev[EV_LOST] = timeout & q.curReady;
    n.irqStat = (q.irqStat & ~clr) | ev;
    n.irq = |(n.irqStat & n.irqMask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= STATE_RST;
    end else begin
      q <= n;
    end
  end

  assign hrdata = q.rdata;
  assign hreadyout = q.hreadyOut;
  assign hresp = q.hresp;
  assign motorRun = q.motorRun;
  assign headLoad = q.headLoad;
  assign readyOutN = q.readyOutN;
  assign ledOn = q.ledOn;
  assign wpOutN = q.wpOutN;
  assign irq = q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  motorLine_a: assert property (q.f.opts.motorFollowsMotorLine && !q.f.pins.motorOnN |=> motorRun)
    else $error("motor not running with motor line low");
  motorSel_a: assert property (q.f.opts.motorFollowsSelect && anySel |=> motorRun)
    else $error("motor not running while selected");
  hlReadyOut_a: assert property (q.f.opts.hlReadySel == HL_SEL_READYOUT |=>
    headLoad == ($past(hlSource) && !readyOutN))
    else $error("head load not qualified by ready output");
  hlCurrent_a: assert property (q.f.opts.hlReadySel == HL_SEL_CURRENT && !q.curReady |=> !headLoad)
    else $error("head loaded without current ready");
  hlHeld_a: assert property (q.f.opts.hlReadySel == HL_SEL_HELD && !heldReady |=> !headLoad)
    else $error("head loaded without held ready");
  rdyCurrent_a: assert property (q.f.opts.readyOutSel == RDY_OUT_CURRENT |=>
    readyOutN == !$past(q.curReady))
    else $error("ready output does not follow current ready");
  rdyHeld_a: assert property (q.f.opts.readyOutSel == RDY_OUT_HELD && heldReady ##1 heldReady |->
    !readyOutN)
    else $error("ready output high with disk seated");
  motorDisk_a: assert property (q.f.opts.motorAlwaysWithDisk && diskIn |=> motorRun)
    else $error("motor off with disk in and constant trace cut");
  ledCut_a: assert property (q.f.opts.inuseInputCut && !selected |=> !ledOn)
    else $error("indicator lit while unselected with in-use cut");
  ledNever_a: assert property (q.f.opts.inuseInputCut && q.f.opts.continuousSelect |=> !ledOn)
    else $error("indicator lit with in-use cut and continuous select");
  wpInvert_a: assert property (1'b1 |=> wpOutN == ($past(q.f.pins.wpSenseN) ^ $past(q.f.opts.wpInvert)))
    else $error("write protect polarity wrong");
  insertSpin_a: assert property (q.disk == DISK_EMPTY && diskIn |=> q.disk == DISK_SPINUP ##1 motorRun)
    else $error("insertion did not start the motor");
  seatPair_a: assert property (q.disk == DISK_READY && $past(q.disk) != DISK_READY |-> $past(pairOk))
    else $error("held ready without an index pair");
  curPair_a: assert property ($rose(q.curReady) |-> $past(pairOk))
    else $error("current ready without an index pair");
  eject_a: assert property (heldReady && !diskIn |=> q.disk == DISK_EMPTY ##1 !q.curReady)
    else $error("eject did not clear held ready");
  hlSource_a: assert property (!hlSource |=> !headLoad)
    else $error("head loaded with no source");
  spinStop_a: assert property (q.disk == DISK_READY && !q.f.opts.motorFollowsMotorLine &&
    !q.f.opts.motorFollowsSelect && !q.f.opts.motorAlwaysWithDisk |=> !motorRun)
    else $error("motor still running after the disk was seated");
  // an event that lands in the read-clear cycle must not be lost
  eventKept_a: assert property (ev != '0 |=> (q.irqStat & $past(ev)) == $past(ev))
    else $error("interrupt event lost");

  lostReady_c: cover property (q.curReady ##1 !q.curReady && diskIn);
  headSel_c: cover property (q.f.opts.headloadOnSelect && headLoad);

  seated_c: cover property (q.disk == DISK_SPINUP ##[1:1000] q.disk == DISK_READY);
  ejected_c: cover property (q.disk == DISK_READY ##1 q.disk == DISK_EMPTY);
  irqRaised_c: cover property (!irq ##1 irq);

endmodule

// ===== fdd_host_model.sv
// host drive lines and the disk mechanism that feeds the index sensor
// assumes one clock shared with the block; all drive lines are active low and idle high
`timescale 1ns/1ps
module fdd_host_model
  import fdd_option_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic motorRun,
  input wire logic diskIn,
  input wire logic clamped,
  input wire logic [15:0] gap,
  input wire logic motorOnN,
  input wire logic [3:0] unitSelN,
  input wire logic inUseN,
  input wire logic wpSenseN,
  output pins_t pins
);
  logic [15:0] cnt;
  // the index hole reaches the sensor only while a clamped disk turns
  wire logic spin = diskIn & clamped & motorRun;
  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 16'h0000;
    end else if (!spin || cnt >= gap - 16'h0001) begin
      cnt <= 16'h0000;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // five clocks wide so the three-flop filter cannot miss a pulse
  always_comb begin
    pins.motorOnN = motorOnN;
    pins.unitSelN = unitSelN;
    pins.inUseN = inUseN;
    pins.indexN = !(spin && cnt < 16'h0005);
    pins.diskInN = !diskIn;
    pins.wpSenseN = wpSenseN;
  end
endmodule

// ===== floppy_drive_option_control_bench.sv
// self-checking bench for the drive option control block
// assumes the host model beside it and a zero-wait AHB-Lite slave; window shortened to 200 clocks
`timescale 1ns/1ps
module floppy_drive_option_control_bench;
  import fdd_option_pkg::*;
  logic clk, rst, motorOnN, inUseN, wp, diskIn, clamped, hsel, hwrite, hreadyout, hresp;
  logic [3:0] sel;
  logic [15:0] gap;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic motorRun, headLoad, readyOutN, ledOn, wpOutN, irq;
  opts_t opts;
  pins_t pins;
  int errCount = 0;
  int nChecks = 0;
  wire logic hready = hreadyout;
  wire logic [5:0] outs = {motorRun, headLoad, readyOutN, ledOn, wpOutN, irq};

  floppy_drive_option_control #(.WINDOW_CYCLES(24'h0000C8)) floppy_drive_option_control_i (.clk(clk),
    .rst(rst), .pinsIn(pins), .optsIn(opts), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .motorRun(motorRun), .headLoad(headLoad), .readyOutN(readyOutN), .ledOn(ledOn), .wpOutN(wpOutN), .irq(irq));
  fdd_host_model fdd_host_model_i (.clk(clk), .rst(rst), .motorRun(motorRun), .diskIn(diskIn),
    .clamped(clamped), .gap(gap), .motorOnN(motorOnN), .unitSelN(sel), .inUseN(inUseN), .wpSenseN(wp),
    .pins(pins));

  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp) begin
      errCount++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chkOut(input logic [5:0] m, input logic [5:0] e);
    chk(32'(outs & m), 32'(e));
  endtask

  // pin changes need five clocks to reach the outputs; eight leaves margin
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  task automatic waitBit(input int b, input logic v, input int lim);
    int n;
    n = 0;
    while (outs[b] !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(32'(outs[b]), 32'(v));
  endtask

  // waits as long as the slave stalls; only the watchdog ends a hung transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
    end while (hready !== 1'b1);
    rd = hrdata;
    chk(32'(hresp), 32'h0);
  endtask

  task automatic wrapUp();
    if (errCount == 0 && nChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task automatic tReset();
    logic [31:0] d;
    chkOut(6'h3F, 6'h0A);
    bus(1'b1, OFF_STATE, 32'hFFFFFFFF, d);
    bus(1'b0, OFF_STATE, 32'h0, d);
    chk(d, 32'h000000C0);
    bus(1'b0, OFF_IRQ_MASK, 32'h0, d);
    chk(d, 32'h0);
    bus(1'b0, 8'h0C, 32'h0, d);
    chk(d, 32'h0);
  endtask

  task automatic tMotor();
    opts_t o;
    o = '0;
    o.motorFollowsMotorLine = 1'b1;
    opts <= o;
    motorOnN <= 1'b0;
    settle();
    chkOut(6'h20, 6'h20);
    o.motorFollowsMotorLine = 1'b0;
    o.motorFollowsSelect = 1'b1;
    opts <= o;
    settle();
    chkOut(6'h20, 6'h00);
    motorOnN <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      sel <= ~(4'h1 << i);
      settle();
      chkOut(6'h20, 6'h20);
    end
    sel <= 4'hF;
    settle();
    chkOut(6'h20, 6'h00);
  endtask

  task automatic tLed();
    opts_t o;
    o = '0;
    o.unitSelect = 4'h1;
    opts <= o;
    inUseN <= 1'b0;
    settle();
    chkOut(6'h04, 6'h04);
    o.inuseInputCut = 1'b1;
    opts <= o;
    settle();
    chkOut(6'h04, 6'h00);
    sel <= 4'hE;
    settle();
    chkOut(6'h04, 6'h04);
    o.continuousSelect = 1'b1;
    opts <= o;
    settle();
    chkOut(6'h04, 6'h00);
    sel <= 4'hF;
    inUseN <= 1'b1;
    settle();
    chkOut(6'h04, 6'h00);
  endtask

  task automatic tWp();
    opts_t o;
    for (int i = 0; i < 4; i++) begin
      o = '0;
      o.wpInvert = i[1];
      opts <= o;
      wp <= i[0];
      settle();
      chkOut(6'h02, {4'h0, i[0] ^ i[1], 1'b0});
    end
  endtask

  task automatic tHeld();
    opts_t o;
    logic [31:0] d;
    o = '0;
    // ready option 4 has no encoding and is never fitted
    o.readyOutSel = RDY_OUT_HELD;
    o.hlReadySel = HL_SEL_HELD;
    o.headloadConstant = 1'b1;
    opts <= o;
    bus(1'b1, OFF_IRQ_MASK, 32'h3, d);
    bus(1'b0, OFF_IRQ_MASK, 32'h0, d);
    chk(d, 32'h3);
    diskIn <= 1'b1;
    clamped <= 1'b0;
    gap <= 16'h0064;
    repeat (400) @(posedge clk);
    chkOut(6'h39, 6'h28);
    clamped <= 1'b1;
    waitBit(3, 1'b0, 600);
    repeat (3) @(posedge clk);
    chkOut(6'h39, 6'h11);
    bus(1'b0, OFF_IRQ_STATUS, 32'h0, d);
    chk(d & 32'h3, 32'h1);
    bus(1'b0, OFF_STATE, 32'h0, d);
    chk(d & 32'h307, 32'h307);
    chkOut(6'h01, 6'h00);
    repeat (300) @(posedge clk);
    bus(1'b0, OFF_STATE, 32'h0, d);
    chk(d & 32'h3, 32'h2);
    chkOut(6'h18, 6'h10);
    o.hlReadySel = HL_SEL_CURRENT;
    opts <= o;
    settle();
    chkOut(6'h10, 6'h00);
    o.hlReadySel = HL_SEL_READYOUT;
    o.motorAlwaysWithDisk = 1'b1;
    opts <= o;
    settle();
    chkOut(6'h30, 6'h30);
    diskIn <= 1'b0;
    clamped <= 1'b0;
    settle();
    chkOut(6'h28, 6'h08);
    bus(1'b0, OFF_STATE, 32'h0, d);
    chk(d & 32'h6, 32'h0);
    bus(1'b0, OFF_IRQ_STATUS, 32'h0, d);
    chk(d & 32'h2, 32'h2);
  endtask

  task automatic tCurrent();
    opts_t o;
    o = '0;
    o.readyOutSel = RDY_OUT_CURRENT;
    o.hlReadySel = HL_SEL_READYOUT;
    o.headloadConstant = 1'b1;
    o.motorFollowsMotorLine = 1'b1;
    opts <= o;
    motorOnN <= 1'b0;
    diskIn <= 1'b1;
    clamped <= 1'b1;
    // index pairs further apart than the window must never qualify
    gap <= 16'h012C;
    repeat (900) @(posedge clk);
    chkOut(6'h18, 6'h08);
    gap <= 16'h0064;
    waitBit(3, 1'b0, 600);
    repeat (3) @(posedge clk);
    chkOut(6'h38, 6'h30);
    o.headloadConstant = 1'b0;
    o.headloadOnSelect = 1'b1;
    o.unitSelect = 4'h1;
    opts <= o;
    settle();
    chkOut(6'h10, 6'h00);
    sel <= 4'hE;
    settle();
    chkOut(6'h10, 6'h10);
    sel <= 4'hF;
    o.headloadOnSelect = 1'b0;
    o.headloadOnMotor = 1'b1;
    opts <= o;
    settle();
    chkOut(6'h10, 6'h10);
    motorOnN <= 1'b1;
    waitBit(3, 1'b1, 400);
    repeat (2) @(posedge clk);
    chkOut(6'h38, 6'h08);
    diskIn <= 1'b0;
    settle();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    wrapUp();
  end

  initial begin
    rst = 1'b1;
    opts = '0;
    motorOnN = 1'b1;
    sel = 4'hF;
    inUseN = 1'b1;
    wp = 1'b1;
    diskIn = 1'b0;
    clamped = 1'b0;
    gap = 16'h0064;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    tReset();
    tMotor();
    tLed();
    tWp();
    tHeld();
    tCurrent();
    wrapUp();
  end
endmodule
